// ===== qcc_asserts.sv
// port assertions of qcc_top
// assumes the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module qcc_asserts (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire logic        PHASE_A,
  input wire logic        PHASE_B,
  input wire logic        INDEX,
  input wire logic        HOME,
  input wire logic        EXT_GATE,
  input wire logic [31:0] POSITION_COUNT
);
  // ****
  // helper: counts down from 5 to 0 after a register write
  // ****
  logic [2:0] wr_age;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) wr_age <= 3'h0;
    else if (PSEL && PWRITE) wr_age <= 3'h5;
    else if (wr_age != 3'h0) wr_age <= wr_age - 3'h1;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence access_begin;
    PSEL && $rose(PENABLE);
  endsequence
  sequence answer_late;
    !PREADY ##1 PREADY;
  endsequence
  access_wait_a: assert property (access_begin |-> answer_late)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  unmapped_err_a: assert property (PREADY && PADDR > 8'h10 |-> PSLVERR)
    else $error("unmapped address accepted");
  err_data_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("error read data not zero");
  read_width_a: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0)
    else $error("read data wider than a register");
  reserved_zero_a: assert property (PREADY && !PWRITE && PADDR == 8'h00
    |-> !PRDATA[14] && !PRDATA[7]) else $error("reserved bit reads one");
  step_one_a: assert property (
    wr_age == 3'h0 && $changed(POSITION_COUNT) |-> POSITION_COUNT == 32'h0
    || POSITION_COUNT - $past(POSITION_COUNT) == 32'h1
    || $past(POSITION_COUNT) - POSITION_COUNT == 32'h1)
    else $error("position moved by more than one");
endmodule
bind qcc_top qcc_asserts i_qcc_asserts (.SYS_CLK(SYS_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .PHASE_A(PHASE_A), .PHASE_B(PHASE_B), .INDEX(INDEX), .HOME(HOME),
  .EXT_GATE(EXT_GATE), .POSITION_COUNT(POSITION_COUNT));
`default_nettype wire

// ===== qcc_defines.svh
// constants of the quadrature counter control block
// assumes a 32-bit apb slave, one word per register
`ifndef QCC_DEFINES_SVH
`define QCC_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define QCC_OFS_CONTROL   8'h00
`define QCC_OFS_PINCFG    8'h04
`define QCC_OFS_POS_LOW   8'h08
`define QCC_OFS_POS_HIGH  8'h0c
`define QCC_OFS_INDEX_CNT 8'h10

// ************************************************************
// control field positions
// ************************************************************
`define QCC_CTL_ENABLE    15
`define QCC_CTL_IDLE_STOP 13
`define QCC_CTL_POSITION_INIT_MODE_HI  12
`define QCC_CTL_POSITION_INIT_MODE_LO  10
`define QCC_CTL_IMV_HI    9
`define QCC_CTL_IMV_LO    8
`define QCC_CTL_DIV_HI    6
`define QCC_CTL_DIV_LO    4
`define QCC_CTL_POL       3
`define QCC_CTL_GATE_EN   2
`define QCC_CTL_MODE_HI   1
`define QCC_CTL_MODE_LO   0
`define QCC_CTL_MASK      16'hb77f

// ************************************************************
// pin config field positions
// ************************************************************
`define QCC_PIN_CFG_HI    15
`define QCC_PIN_CFG_LO    4
`define QCC_PIN_SWAP      8
`define QCC_PIN_HOME_POL  7
`define QCC_PIN_INDEX_POL 6
`define QCC_PIN_B_POL     5
`define QCC_PIN_A_POL     4

// ************************************************************
// reset values and init mode codes
// ************************************************************
`define QCC_RST_CONTROL   16'h0000
`define QCC_RST_PINCFG    12'h000
`define QCC_POSITION_INIT_MODE_INDEX   3'h1

`endif

// ===== qcc_encoder_model.sv
// incremental encoder with gate pin, driven by task calls
// assumes tasks are called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module qcc_encoder_model (
  input  wire logic clk,
  output logic      phase_a,
  output logic      phase_b,
  output logic      index_pulse,
  output logic      home,
  output logic      gate
);
  initial begin
    {phase_a, phase_b, index_pulse, home, gate} = 5'h0;
  end
  // slow edges keep the counter clock above twice the rate
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask
  // forward means phase a leads phase b
  task automatic quad(input logic fwd);
    if (fwd == (phase_a == phase_b)) phase_a <= !phase_a;
    else phase_b <= !phase_b;
    settle();
  endtask
  task automatic pulse_a();
    phase_a <= 1'b1;
    settle();
    phase_a <= 1'b0;
    settle();
  endtask
  task automatic set_b(input logic v);
    phase_b <= v;
    settle();
  endtask
  task automatic set_gate(input logic v);
    gate <= v;
    settle();
  endtask
  task automatic pulse_index();
    index_pulse <= 1'b1;
    settle();
    index_pulse <= 1'b0;
    settle();
  endtask
  task automatic set_home(input logic v);
    home <= v;
    settle();
  endtask
endmodule
`default_nettype wire

// ===== qcc_pkg.sv
// types of the quadrature counter control block
// assumes qcc_defines.svh supplies the numeric constants
package qcc_pkg;

  // ************************************************************
  // counter modes
  // ************************************************************
  typedef enum logic [1:0] {
    QCC_MODE_QUAD     = 2'h0,
    QCC_MODE_EXT_DIR  = 2'h1,
    QCC_MODE_EXT_GATE = 2'h2,
    QCC_MODE_TIMER    = 2'h3
  } qcc_mode_t;

endpackage

// ===== qcc_top.sv
// quadrature counter control: prescaler, modes, position and index counters
// assumes an apb master on SYS_CLK and encoder pins from outside the domain
`timescale 1ns/1ps
`include "qcc_defines.svh"
`default_nettype none

// What this block does
// - three-bit prescale divides internal counter clock by 1 up to 128.
// - polarity bit one counts negative, zero positive; up/down input may flip.
// - gate enable one lets external gate stop the position counter.
// - mode 11 counts prescaled internal clock as a timer.
// - mode 10 counts external clock pulses while the gate is high.
// - mode 01 counts external clock pulses, direction from up/down input.
// - mode 00 decodes phase A and B into position counts.
// - modes 10 and 11 run the index counter as a timer, init mode ignored.
// - mode 00: phase levels equal match value reset the position counter.
module qcc_top
  import qcc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic        PHASE_A,
  input  wire logic        PHASE_B,
  input  wire logic        INDEX,
  input  wire logic        HOME,
  input  wire logic        EXT_GATE,
  output logic [31:0]      POSITION_COUNT
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0] control;
  logic [11:0] pin_config;
  logic [31:0] position;
  logic [15:0] index_count;
  logic [6:0]  prescale_cnt;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [4:0] pin_raw;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pin_clean;

  assign pin_raw = {EXT_GATE, HOME, INDEX, PHASE_B, PHASE_A};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          sync1[gi]     <= 1'b0;
          sync2[gi]     <= 1'b0;
          sync3[gi]     <= 1'b0;
          pin_clean[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_clean[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // polarity and swap
  // ************************************************************
  logic pa_pol;
  logic pb_pol;
  logic phase_a;
  logic phase_b;
  logic index_in;
  logic home_in;
  logic gate_in;

  assign pa_pol   = pin_clean[0] ^ pin_config[`QCC_PIN_A_POL - 4];
  assign pb_pol   = pin_clean[1] ^ pin_config[`QCC_PIN_B_POL - 4];
  assign phase_a  = pin_config[`QCC_PIN_SWAP - 4] ? pb_pol : pa_pol;
  assign phase_b  = pin_config[`QCC_PIN_SWAP - 4] ? pa_pol : pb_pol;
  assign index_in = pin_clean[2] ^ pin_config[`QCC_PIN_INDEX_POL - 4];
  assign home_in  = pin_clean[3] ^ pin_config[`QCC_PIN_HOME_POL - 4];
  assign gate_in  = pin_clean[4];

  // ************************************************************
  // control fields
  // ************************************************************
  qcc_mode_t   mode;
  logic        enable;
  logic [2:0]  init_mode;
  logic [1:0]  match_value;
  logic [2:0]  prescale;
  logic        polarity;
  logic        gate_en;

  assign mode        = qcc_mode_t'(control[`QCC_CTL_MODE_HI:`QCC_CTL_MODE_LO]);
  assign enable      = control[`QCC_CTL_ENABLE];
  assign init_mode   = control[`QCC_CTL_POSITION_INIT_MODE_HI:`QCC_CTL_POSITION_INIT_MODE_LO];
  assign match_value = control[`QCC_CTL_IMV_HI:`QCC_CTL_IMV_LO];
  assign prescale    = control[`QCC_CTL_DIV_HI:`QCC_CTL_DIV_LO];
  assign polarity    = control[`QCC_CTL_POL];
  assign gate_en     = control[`QCC_CTL_GATE_EN];

  // ************************************************************
  // apb access
  // ************************************************************
  logic apb_write;
  logic wr_control;
  logic wr_pincfg;
  logic wr_pos_low;
  logic wr_pos_high;
  logic wr_index;
  logic addr_ok;

  assign apb_write   = PSEL & PENABLE & PREADY & PWRITE;
  assign wr_control  = apb_write & (PADDR == `QCC_OFS_CONTROL);
  assign wr_pincfg   = apb_write & (PADDR == `QCC_OFS_PINCFG);
  assign wr_pos_low  = apb_write & (PADDR == `QCC_OFS_POS_LOW);
  assign wr_pos_high = apb_write & (PADDR == `QCC_OFS_POS_HIGH);
  assign wr_index    = apb_write & (PADDR == `QCC_OFS_INDEX_CNT);
  assign addr_ok     = (PADDR == `QCC_OFS_CONTROL)
                     | (PADDR == `QCC_OFS_PINCFG)
                     | (PADDR == `QCC_OFS_POS_LOW)
                     | (PADDR == `QCC_OFS_POS_HIGH)
                     | (PADDR == `QCC_OFS_INDEX_CNT);

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (PADDR)
      `QCC_OFS_CONTROL:   next_prdata = {16'h0000, control};
      `QCC_OFS_PINCFG:    next_prdata = {16'h0000, pin_config,
                                         home_in, index_in, phase_b, phase_a};
      `QCC_OFS_POS_LOW:   next_prdata = {16'h0000, position[15:0]};
      `QCC_OFS_POS_HIGH:  next_prdata = {16'h0000, position[31:16]};
      `QCC_OFS_INDEX_CNT: next_prdata = {16'h0000, index_count};
      default:            next_prdata = 32'h0000_0000;
    endcase
  end

  // one wait state, then ready for one cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
        PRDATA <= next_prdata;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      control    <= `QCC_RST_CONTROL;
      pin_config <= `QCC_RST_PINCFG;
    end else begin
      if (wr_control) begin
        control <= PWDATA[15:0] & `QCC_CTL_MASK;
      end
      if (wr_pincfg) begin
        pin_config <= PWDATA[`QCC_PIN_CFG_HI:`QCC_PIN_CFG_LO];
      end
    end
  end

  // ************************************************************
  // prescaler
  // ************************************************************
  logic [7:0] prescale_span;
  logic       tick;

  assign prescale_span = (8'h01 << prescale) - 8'h01;
  assign tick = enable
              & ((prescale_cnt & prescale_span[6:0]) == prescale_span[6:0]);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prescale_cnt <= 7'h00;
    end else if (!enable) begin
      prescale_cnt <= 7'h00;
    end else begin
      prescale_cnt <= prescale_cnt + 7'h01;
    end
  end

  // ************************************************************
  // edge detection
  // ************************************************************
  logic a_prev;
  logic b_prev;
  logic index_prev;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      a_prev     <= 1'b0;
      b_prev     <= 1'b0;
      index_prev <= 1'b0;
    end else begin
      a_prev     <= phase_a;
      b_prev     <= phase_b;
      index_prev <= index_in;
    end
  end

  logic quad_edge;
  logic quad_fwd;
  logic a_rise;
  logic index_rise;

  assign quad_edge  = (phase_a ^ a_prev) ^ (phase_b ^ b_prev);
  assign quad_fwd   = phase_a ^ b_prev;
  assign a_rise     = phase_a & ~a_prev;
  assign index_rise = index_in & ~index_prev;

  // ************************************************************
  // mode select
  // ************************************************************
  logic step;
  logic count_up;
  logic gate_ok;
  logic timer_mode;

  assign gate_ok    = ~gate_en | gate_in;
  assign timer_mode = (mode == QCC_MODE_EXT_GATE) | (mode == QCC_MODE_TIMER);

  always_comb begin
    step     = 1'b0;
    count_up = ~polarity;
    case (mode)
      QCC_MODE_QUAD: begin
        step     = quad_edge;
        count_up = quad_fwd ^ polarity;
      end
      QCC_MODE_EXT_DIR: begin
        step     = a_rise;
        count_up = phase_b ^ polarity;
      end
      QCC_MODE_EXT_GATE: begin
        step = a_rise & gate_in;
      end
      QCC_MODE_TIMER: begin
        step = tick;
      end
      default: begin
        step = 1'b0;
      end
    endcase
  end

  logic match_reset;
  logic index_reset;

  assign match_reset = enable & (mode == QCC_MODE_QUAD)
                     & ({phase_b, phase_a} == match_value);
  assign index_reset = enable & ~timer_mode & index_rise
                     & (init_mode == `QCC_POSITION_INIT_MODE_INDEX);

  // ************************************************************
  // position counter
  // ************************************************************
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      position <= 32'h0000_0000;
    end else if (wr_pos_low) begin
      position[15:0] <= PWDATA[15:0];
    end else if (wr_pos_high) begin
      position[31:16] <= PWDATA[15:0];
    end else if (match_reset) begin
      position <= 32'h0000_0000;
    end else if (index_reset) begin
      position <= 32'h0000_0000;
    end else if (enable & step & gate_ok) begin
      position <= count_up ? position + 32'h0000_0001
                           : position - 32'h0000_0001;
    end
  end

  // ************************************************************
  // index counter
  // ************************************************************
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      index_count <= 16'h0000;
    end else if (wr_index) begin
      index_count <= PWDATA[15:0];
    end else if (enable & timer_mode & tick) begin
      index_count <= count_up ? index_count + 16'h0001
                              : index_count - 16'h0001;
    end else if (enable & ~timer_mode & index_rise) begin
      index_count <= count_up ? index_count + 16'h0001
                              : index_count - 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      POSITION_COUNT <= 32'h0000_0000;
    end else begin
      POSITION_COUNT <= position;
    end
  end

endmodule

`default_nettype wire

// ===== qcc_top_end.sv
// no logic of its own: the whole block sits in qcc_top.sv

// ===== tb.sv
// self-checking bench of qcc_top over apb
// assumes the encoder model and the bound checker
`timescale 1ns/1ps
`include "qcc_defines.svh"
`default_nettype none
module tb;
  import qcc_pkg::*;
  logic        sys_clk, rst, psel, penable, pwrite, er;
  logic        pready, pslverr, ph_a, ph_b, idx, home, gate;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pos, rd, p0;
  int          miscompares, num_checks;
  always #20 sys_clk = !sys_clk;
  qcc_top i_qcc_top (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PHASE_A(ph_a),
    .PHASE_B(ph_b), .INDEX(idx), .HOME(home), .EXT_GATE(gate),
    .POSITION_COUNT(pos));
  qcc_encoder_model i_qcc_encoder_model (.clk(sys_clk), .phase_a(ph_a),
    .phase_b(ph_b), .index_pulse(idx), .home(home), .gate(gate));
  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // idle stop and match value stay clear, init mode 000
  function automatic logic [15:0] ctl(input logic [2:0] dv,
    input logic pol, input logic gt, input qcc_mode_t m);
    return {1'b1, 7'h0, 1'b0, dv, pol, gt, m};
  endfunction
  task automatic start(input logic [15:0] c);
    apb(1'b1, `QCC_OFS_CONTROL, 16'h0);
    apb(1'b1, `QCC_OFS_POS_LOW, 16'h0);
    apb(1'b1, `QCC_OFS_POS_HIGH, 16'h0);
    apb(1'b1, `QCC_OFS_CONTROL, c);
  endtask
  // ****
  // tests
  // ****
  initial begin
    {sys_clk, psel, penable, pwrite, paddr, pwdata} = 'h0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `QCC_OFS_CONTROL, 16'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 16'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, `QCC_OFS_CONTROL, 16'hffff);
    apb(1'b0, `QCC_OFS_CONTROL, 16'h0);
    check(rd, 32'h0000b77f);
    $display("register test done");
    start(ctl(3'h0, 1'b0, 1'b0, QCC_MODE_QUAD));
    for (int i = 0; i < 4; i++) begin
      i_qcc_encoder_model.quad(1'b1);
      check(pos, (i + 1) % 4);
    end
    apb(1'b1, `QCC_OFS_CONTROL, ctl(3'h0, 1'b1, 1'b0, QCC_MODE_QUAD));
    i_qcc_encoder_model.quad(1'b1);
    check(pos, 32'hffffffff);
    i_qcc_encoder_model.quad(1'b0);
    check(pos, 32'h0);
    apb(1'b1, `QCC_OFS_CONTROL,
        ctl(3'h0, 1'b0, 1'b0, QCC_MODE_QUAD) | 16'h0100);
    i_qcc_encoder_model.quad(1'b1);
    check(pos, 32'h0);
    i_qcc_encoder_model.quad(1'b1);
    check(pos, 32'h1);
    i_qcc_encoder_model.quad(1'b0);
    i_qcc_encoder_model.quad(1'b0);
    check(pos, 32'hffffffff);
    i_qcc_encoder_model.set_home(1'b1);
    apb(1'b0, `QCC_OFS_PINCFG, 16'h0);
    check(rd, 32'h8);
    $display("quadrature test done");
    start(ctl(3'h0, 1'b0, 1'b0, QCC_MODE_EXT_DIR));
    i_qcc_encoder_model.set_b(1'b1);
    i_qcc_encoder_model.pulse_a();
    i_qcc_encoder_model.pulse_a();
    check(pos, 32'h2);
    i_qcc_encoder_model.set_b(1'b0);
    i_qcc_encoder_model.pulse_a();
    check(pos, 32'h1);
    apb(1'b1, `QCC_OFS_CONTROL, ctl(3'h0, 1'b0, 1'b1, QCC_MODE_EXT_DIR));
    i_qcc_encoder_model.pulse_a();
    check(pos, 32'h1);
    i_qcc_encoder_model.set_gate(1'b1);
    i_qcc_encoder_model.pulse_a();
    check(pos, 32'h0);
    apb(1'b1, `QCC_OFS_INDEX_CNT, 16'h0);
    apb(1'b1, `QCC_OFS_CONTROL,
        ctl(3'h0, 1'b0, 1'b0, QCC_MODE_EXT_DIR) | 16'h0400);
    i_qcc_encoder_model.pulse_a();
    check(pos, 32'hffffffff);
    i_qcc_encoder_model.pulse_index();
    check(pos, 32'h0);
    apb(1'b0, `QCC_OFS_INDEX_CNT, 16'h0);
    check(rd, 32'h0000ffff);
    start(ctl(3'h0, 1'b0, 1'b0, QCC_MODE_EXT_GATE) | 16'h0400);
    i_qcc_encoder_model.pulse_a();
    check(pos, 32'h1);
    i_qcc_encoder_model.pulse_index();
    check(pos, 32'h1);
    i_qcc_encoder_model.set_gate(1'b0);
    i_qcc_encoder_model.pulse_a();
    check(pos, 32'h1);
    $display("external clock test done");
    for (int p = 0; p < 8; p++) begin
      start(ctl(3'(p), p[0], 1'b0, QCC_MODE_TIMER));
      repeat (4) @(posedge sys_clk);
      p0 = pos;
      repeat (8 << p) @(posedge sys_clk);
      check(pos - p0, p[0] ? 32'hfffffff8 : 32'h8);
    end
    apb(1'b1, `QCC_OFS_CONTROL, 16'h0);
    apb(1'b1, `QCC_OFS_INDEX_CNT, 16'h0);
    apb(1'b1, `QCC_OFS_CONTROL, ctl(3'h7, 1'b1, 1'b0, QCC_MODE_TIMER));
    repeat (150) @(posedge sys_clk);
    apb(1'b0, `QCC_OFS_INDEX_CNT, 16'h0);
    check(rd, 32'h0000ffff);
    $display("timer test done");
    conclude();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
